// >>> pkg/icb_cfg_if.sv
// Purpose: Configuration carried from the register bank to its helpers
// Assumes: All members are registered in the bank
// Notes: One producer, two consumer views
`timescale 1ns/1ps
`default_nettype none
interface icb_cfg_if;
   logic irq_pol;
   logic irq_od;
   logic auto_inc;
   logic [1:0] wrap_sel;
   modport ctrl (output irq_pol, output irq_od, output auto_inc, output wrap_sel);
   modport pin (input irq_pol, input irq_od);
   modport ptr (input auto_inc, input wrap_sel);
endinterface : icb_cfg_if
`default_nettype wire

// >>> pkg/icb_pkg.sv
// Purpose: Shared constants and types of the inertial control register bank
// Assumes: 7-bit register address space, 8-bit registers
// Notes: Data pair and output regions sit at addresses of this block's own layout
package icb_pkg;

   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam logic [6:0] ADDR_IFACE_RESET = 7'h12;
   localparam logic [6:0] ADDR_IRQ_ROUTE = 7'h13;
   localparam logic [6:0] ADDR_POWER_WRAP = 7'h14;
   localparam logic [6:0] ADDR_TRIG_OFS = 7'h15;
   localparam logic [6:0] ADDR_GYRO_FIRST = 7'h22;
   localparam logic [6:0] ADDR_GYRO_LAST = 7'h27;
   localparam logic [6:0] ADDR_ACC_FIRST = 7'h28;
   localparam logic [6:0] ADDR_ACC_LAST = 7'h2d;
   localparam logic [6:0] ADDR_DATA_LO = 7'h22;
   localparam logic [6:0] ADDR_DATA_HI = 7'h23;

   // ---------------------------------------------------------------
   // Reset values and storable bits
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_IFACE_RESET = 8'h04;
   localparam logic [7:0] RST_IRQ_ROUTE = 8'h00;
   localparam logic [7:0] RST_POWER_WRAP = 8'h00;
   localparam logic [7:0] RST_TRIG_OFS = 8'h00;
   localparam logic [7:0] MASK_IFACE_RESET = 8'h7c;
   localparam logic [7:0] MASK_IRQ_ROUTE = 8'h6e;
   localparam logic [7:0] MASK_POWER_WRAP = 8'hef;
   localparam logic [7:0] MASK_TRIG_OFS = 8'hff;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_RELOAD = 7;
   localparam int BIT_HOLD = 6;
   localparam int BIT_POL = 5;
   localparam int BIT_DRV = 4;
   localparam int BIT_SIM = 3;
   localparam int BIT_INC = 2;
   localparam int BIT_SWRST = 0;
   localparam int BIT_SLEEP_G = 6;
   localparam int BIT_MERGE = 5;
   localparam int BIT_HIDE = 3;
   localparam int BIT_I2C_OFF = 2;
   localparam int BIT_LPF1 = 1;
   localparam int BIT_ULP = 7;
   localparam int WRAP_LSB = 5;
   localparam int GST_LSB = 2;
   localparam int AST_LSB = 0;
   localparam int BIT_EDGE = 7;
   localparam int BIT_LEVEL = 6;
   localparam int BIT_LATCH = 5;
   localparam int BIT_HP_OFF = 4;
   localparam int BIT_OFS_W = 3;
   localparam int BW_LSB = 0;

   // ---------------------------------------------------------------
   // Encodings and timing
   // ---------------------------------------------------------------
   localparam logic [1:0] WRAP_ACC = 2'h1;
   localparam logic [1:0] WRAP_GYRO = 2'h2;
   localparam logic [1:0] WRAP_BOTH = 2'h3;
   localparam logic [1:0] GST_BAD = 2'h2;
   localparam logic [1:0] AST_BAD = 2'h3;
   localparam int DEF_RELOAD_CYCLES = 16;

   typedef enum logic [2:0] {TRIG_NONE, TRIG_EDGE, TRIG_LEVEL, TRIG_LATCHED, TRIG_LEVEL_FIFO} icb_trig_mode_t;
   typedef enum logic {BOOT_IDLE, BOOT_BUSY} icb_boot_state_t;

endpackage : icb_pkg

// >>> rtl/icb_addr_ptr.sv
// Purpose: Register address pointer for multi-byte serial accesses
// Assumes: start and step are single-cycle strobes
// Notes: Wrap regions follow the burst wrap field
`timescale 1ns/1ps
`default_nettype none
module icb_addr_ptr (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [6:0] start_addr,
   input wire logic step,
   icb_cfg_if.ptr cfg,
   output logic [6:0] cur_addr
);
   logic [6:0] addr_reg;
   logic [6:0] addr_next;

   assign cur_addr = start ? start_addr : addr_reg;

   always_comb begin
      addr_next = cur_addr + 7'h01;
      if (cfg.wrap_sel == icb_pkg::WRAP_BOTH && cur_addr == icb_pkg::ADDR_ACC_LAST) begin
         addr_next = icb_pkg::ADDR_GYRO_FIRST; // [RQ14]
      end else if (cfg.wrap_sel == icb_pkg::WRAP_ACC && cur_addr == icb_pkg::ADDR_ACC_LAST) begin
         addr_next = icb_pkg::ADDR_ACC_FIRST; // [RQ14]
      end else if (cfg.wrap_sel == icb_pkg::WRAP_GYRO && cur_addr == icb_pkg::ADDR_GYRO_LAST) begin
         addr_next = icb_pkg::ADDR_GYRO_FIRST; // [RQ14]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= 7'h00;
      end else if (step && cfg.auto_inc) begin
         addr_reg <= addr_next; // [RQ6]
      end else if (start) begin
         addr_reg <= start_addr;
      end
   end
endmodule : icb_addr_ptr
`default_nettype wire

// >>> rtl/icb_ctrl_bank.sv
// Purpose: Four 8-bit control registers of an inertial sensor and their effects
// Assumes: Serial protocol engine outside issues byte strobes on the access port
// Notes: All top outputs are registered
//
// Notes on behaviour
// RQ1: Writing 1 to reload bit starts memory reload; bit self-clears, resets 0.
// RQ2: Update-hold freezes the data pair until both bytes are read.
// RQ3: Polarity bit selects active high (0) or low (1) on both pins.
// RQ4: Drive bit selects push-pull (0) or open-drain (1) on both pins.
// RQ5: Wire mode bit selects 4-wire (0) or 3-wire (1) port; host matches.
// RQ6: Auto-advance bit (reset 1) increments address after each access byte.
// RQ7: Writing 1 to soft reset restores defaults; bit self-clears.
// RQ8: Gyro doze bit puts the angular rate sensor to sleep.
// RQ9: Merge bit ORs all interrupt sources onto the first pin.
// RQ10: Ready-hide masks data-ready until settling, accel and gyro independently.
// RQ11: Two-wire disable bit turns off the I2C port, SPI stays usable.
// RQ12: Gyro first low-pass enabled only while auxiliary SPI is disabled.
// RQ13: Ultra-low-power bit enables accelerometer ultra-low-power mode.
// RQ14: Burst wrap field: none, accel, gyro or both output regions.
// RQ15: Gyro self-test 00 normal, 01 positive, 11 negative; 10 forbidden.
// RQ16: Accel self-test 00 normal, 01 positive, 10 negative; 11 forbidden.
// RQ17: Three bits configure the external data-enable trigger behaviour.
// RQ18: Trigger bits decode 100 edge, 010 level, 011 latched, 110 FIFO.
// RQ19: High-performance disable bit allows accelerometer low-power and normal rates.
// RQ20: Offset weight bit scales user offsets, 2^-10 or 2^-6 g per LSB.
// RQ21: Gyro bandwidth field selects the first low-pass stage bandwidth.
// RQ22: Host writes zero to fixed-zero bits and preserves them.
`timescale 1ns/1ps
`default_nettype none
module icb_ctrl_bank #(
   parameter int RELOAD_CYCLES = icb_pkg::DEF_RELOAD_CYCLES
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // Register access port
   input wire logic ACC_START_IN,
   input wire logic [6:0] ACC_ADDR_IN,
   input wire logic ACC_WR_IN,
   input wire logic ACC_RD_IN,
   input wire logic [7:0] ACC_WDATA_IN,
   output logic [7:0] ACC_RDATA_OUT,
   output logic ACC_RVALID_OUT,
   // Sensor side
   input wire logic [15:0] GYRO_DATA_IN,
   input wire logic GYRO_DATA_VALID_IN,
   input wire logic DATA_READY_INDICATION_XL_IN,
   input wire logic DATA_READY_INDICATION_G_IN,
   input wire logic SETTLE_XL_IN,
   input wire logic SETTLE_G_IN,
   input wire logic IRQ_SRC_A_IN,
   input wire logic IRQ_SRC_B_IN,
   input wire logic AUX_SPI_EN_IN,
   // Interrupt pins
   output logic IRQ_A_OUT,
   output logic IRQ_A_OE_OUT,
   output logic IRQ_B_OUT,
   output logic IRQ_B_OE_OUT,
   // Device control
   output logic RELOAD_BUSY_OUT,
   output logic SOFT_RESET_OUT,
   output logic SPI_3WIRE_OUT,
   output logic I2C_PORT_EN_OUT,
   output logic GYRO_SLEEP_OUT,
   output logic GYRO_LPF1_EN_OUT,
   output logic [2:0] GYRO_BW_OUT,
   output logic [1:0] GYRO_ST_OUT,
   output logic [1:0] ACCEL_ST_OUT,
   output logic ACCEL_ULP_OUT,
   output logic ACCEL_HP_OFF_OUT,
   output logic OFFSET_WEIGHT_OUT,
   output logic [2:0] TRIG_MODE_OUT
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam int BOOT_BOUND = 40;
   logic [7:0] iface_reg;
   logic [7:0] route_reg;
   logic [7:0] power_reg;
   logic [7:0] trig_reg;
   logic [6:0] cur_addr;
   logic step;
   logic wr_iface;
   logic swrst_req;
   logic boot_req;
   icb_pkg::icb_boot_state_t boot_state;
   logic [15:0] boot_cnt;
   logic [15:0] data_hold_reg;
   logic lo_read_reg;
   logic hi_read_reg;
   logic pair_rd;
   logic data_load;
   logic pin_a_act;
   logic pin_b_act;
   logic data_ready_indication_xl_vis;
   logic data_ready_indication_g_vis;
   icb_cfg_if cfg_bus ();

   assign step = ACC_WR_IN | ACC_RD_IN;
   assign wr_iface = ACC_WR_IN && cur_addr == icb_pkg::ADDR_IFACE_RESET;
   assign swrst_req = wr_iface && ACC_WDATA_IN[icb_pkg::BIT_SWRST];
   assign boot_req = wr_iface && ACC_WDATA_IN[icb_pkg::BIT_RELOAD] && !ACC_WDATA_IN[icb_pkg::BIT_SWRST];

   // ---------------------------------------------------------------
   // Address pointer
   // ---------------------------------------------------------------
   icb_addr_ptr u_ptr (
      .clk(CLK_IN),
      .rst_n(RST_N_IN),
      .start(ACC_START_IN),
      .start_addr(ACC_ADDR_IN),
      .step(step),
      .cfg(cfg_bus.ptr),
      .cur_addr(cur_addr)
   );

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   // Soft reset beats any field written alongside it
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         iface_reg <= icb_pkg::RST_IFACE_RESET;
         route_reg <= icb_pkg::RST_IRQ_ROUTE;
         power_reg <= icb_pkg::RST_POWER_WRAP;
         trig_reg <= icb_pkg::RST_TRIG_OFS;
      end else if (swrst_req) begin
         iface_reg <= icb_pkg::RST_IFACE_RESET; // [RQ7]
         route_reg <= icb_pkg::RST_IRQ_ROUTE; // [RQ7]
         power_reg <= icb_pkg::RST_POWER_WRAP; // [RQ7]
         trig_reg <= icb_pkg::RST_TRIG_OFS; // [RQ7]
      end else if (ACC_WR_IN) begin
         case (cur_addr)
            icb_pkg::ADDR_IFACE_RESET: iface_reg <= ACC_WDATA_IN & icb_pkg::MASK_IFACE_RESET;
            icb_pkg::ADDR_IRQ_ROUTE: route_reg <= ACC_WDATA_IN & icb_pkg::MASK_IRQ_ROUTE;
            icb_pkg::ADDR_POWER_WRAP: power_reg <= ACC_WDATA_IN & icb_pkg::MASK_POWER_WRAP;
            icb_pkg::ADDR_TRIG_OFS: trig_reg <= ACC_WDATA_IN & icb_pkg::MASK_TRIG_OFS;
            default: ;
         endcase
      end
   end

   assign cfg_bus.irq_pol = iface_reg[icb_pkg::BIT_POL];
   assign cfg_bus.irq_od = iface_reg[icb_pkg::BIT_DRV];
   assign cfg_bus.auto_inc = iface_reg[icb_pkg::BIT_INC];
   assign cfg_bus.wrap_sel = power_reg[icb_pkg::WRAP_LSB +: 2];

   // ---------------------------------------------------------------
   // Memory reload sequencer
   // ---------------------------------------------------------------
   // A reload in flight is abandoned by a soft reset
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         boot_state <= icb_pkg::BOOT_IDLE;
         boot_cnt <= 16'h0000;
      end else if (swrst_req) begin
         boot_state <= icb_pkg::BOOT_IDLE;
         boot_cnt <= 16'h0000;
      end else begin
         case (boot_state)
            icb_pkg::BOOT_IDLE: begin
               if (boot_req) begin
                  boot_state <= icb_pkg::BOOT_BUSY; // [RQ1]
                  boot_cnt <= 16'(RELOAD_CYCLES - 1);
               end
            end
            icb_pkg::BOOT_BUSY: begin
               if (boot_cnt == 16'h0000) begin
                  boot_state <= icb_pkg::BOOT_IDLE; // [RQ1]
               end else begin
                  boot_cnt <= boot_cnt - 16'h0001;
               end
            end
            default: boot_state <= icb_pkg::BOOT_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output data pair with update hold
   // ---------------------------------------------------------------
   // A read of the pair defers a load by one valid strobe so no byte tears
   assign pair_rd = ACC_RD_IN && (cur_addr == icb_pkg::ADDR_DATA_LO || cur_addr == icb_pkg::ADDR_DATA_HI);
   assign data_load = GYRO_DATA_VALID_IN && !pair_rd &&
      (!iface_reg[icb_pkg::BIT_HOLD] || (lo_read_reg && hi_read_reg)); // [RQ2]

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         data_hold_reg <= 16'h0000;
         lo_read_reg <= 1'b1;
         hi_read_reg <= 1'b1;
      end else if (data_load) begin
         data_hold_reg <= GYRO_DATA_IN;
         lo_read_reg <= 1'b0;
         hi_read_reg <= 1'b0;
      end else if (pair_rd) begin
         lo_read_reg <= lo_read_reg | (cur_addr == icb_pkg::ADDR_DATA_LO); // [RQ2]
         hi_read_reg <= hi_read_reg | (cur_addr == icb_pkg::ADDR_DATA_HI); // [RQ2]
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ACC_RDATA_OUT <= 8'h00;
         ACC_RVALID_OUT <= 1'b0;
      end else begin
         ACC_RVALID_OUT <= ACC_RD_IN;
         if (ACC_RD_IN) begin
            case (cur_addr)
               icb_pkg::ADDR_IFACE_RESET: ACC_RDATA_OUT <= {boot_state == icb_pkg::BOOT_BUSY, iface_reg[6:0]};
               icb_pkg::ADDR_IRQ_ROUTE: ACC_RDATA_OUT <= route_reg;
               icb_pkg::ADDR_POWER_WRAP: ACC_RDATA_OUT <= power_reg;
               icb_pkg::ADDR_TRIG_OFS: ACC_RDATA_OUT <= trig_reg;
               icb_pkg::ADDR_DATA_LO: ACC_RDATA_OUT <= data_hold_reg[7:0];
               icb_pkg::ADDR_DATA_HI: ACC_RDATA_OUT <= data_hold_reg[15:8];
               default: ACC_RDATA_OUT <= 8'h00;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt routing
   // ---------------------------------------------------------------
   assign data_ready_indication_xl_vis = DATA_READY_INDICATION_XL_IN && !(route_reg[icb_pkg::BIT_HIDE] && SETTLE_XL_IN); // [RQ10]
   assign data_ready_indication_g_vis = DATA_READY_INDICATION_G_IN && !(route_reg[icb_pkg::BIT_HIDE] && SETTLE_G_IN); // [RQ10]
   assign pin_a_act = IRQ_SRC_A_IN || data_ready_indication_xl_vis ||
      (route_reg[icb_pkg::BIT_MERGE] && (IRQ_SRC_B_IN || data_ready_indication_g_vis)); // [RQ9]
   assign pin_b_act = !route_reg[icb_pkg::BIT_MERGE] && (IRQ_SRC_B_IN || data_ready_indication_g_vis); // [RQ9]

   icb_irq_pin u_pin_a (
      .clk(CLK_IN),
      .rst_n(RST_N_IN),
      .active(pin_a_act),
      .cfg(cfg_bus.pin),
      .pin_out(IRQ_A_OUT),
      .pin_oe(IRQ_A_OE_OUT)
   );

   icb_irq_pin u_pin_b (
      .clk(CLK_IN),
      .rst_n(RST_N_IN),
      .active(pin_b_act),
      .cfg(cfg_bus.pin),
      .pin_out(IRQ_B_OUT),
      .pin_oe(IRQ_B_OE_OUT)
   );

   // ---------------------------------------------------------------
   // Device control outputs
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         RELOAD_BUSY_OUT <= 1'b0;
         SOFT_RESET_OUT <= 1'b0;
      end else begin
         RELOAD_BUSY_OUT <= boot_req || (boot_state == icb_pkg::BOOT_BUSY && boot_cnt != 16'h0000); // [RQ1]
         SOFT_RESET_OUT <= swrst_req; // [RQ7]
      end
   end

   // Forbidden self-test codes fall back to normal operation rather than an undefined stimulus
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         SPI_3WIRE_OUT <= 1'b0;
         I2C_PORT_EN_OUT <= 1'b1;
         GYRO_SLEEP_OUT <= 1'b0;
         GYRO_LPF1_EN_OUT <= 1'b0;
         GYRO_BW_OUT <= 3'h0;
         GYRO_ST_OUT <= 2'h0;
         ACCEL_ST_OUT <= 2'h0;
         ACCEL_ULP_OUT <= 1'b0;
         ACCEL_HP_OFF_OUT <= 1'b0;
         OFFSET_WEIGHT_OUT <= 1'b0;
      end else begin
         SPI_3WIRE_OUT <= iface_reg[icb_pkg::BIT_SIM]; // [RQ5]
         I2C_PORT_EN_OUT <= !route_reg[icb_pkg::BIT_I2C_OFF]; // [RQ11]
         GYRO_SLEEP_OUT <= route_reg[icb_pkg::BIT_SLEEP_G]; // [RQ8]
         GYRO_LPF1_EN_OUT <= route_reg[icb_pkg::BIT_LPF1] && !AUX_SPI_EN_IN; // [RQ12]
         GYRO_BW_OUT <= trig_reg[icb_pkg::BW_LSB +: 3]; // [RQ21]
         GYRO_ST_OUT <= (power_reg[icb_pkg::GST_LSB +: 2] == icb_pkg::GST_BAD) ? 2'h0 :
            power_reg[icb_pkg::GST_LSB +: 2]; // [RQ15]
         ACCEL_ST_OUT <= (power_reg[icb_pkg::AST_LSB +: 2] == icb_pkg::AST_BAD) ? 2'h0 :
            power_reg[icb_pkg::AST_LSB +: 2]; // [RQ16]
         ACCEL_ULP_OUT <= power_reg[icb_pkg::BIT_ULP]; // [RQ13]
         ACCEL_HP_OFF_OUT <= trig_reg[icb_pkg::BIT_HP_OFF]; // [RQ19]
         OFFSET_WEIGHT_OUT <= trig_reg[icb_pkg::BIT_OFS_W]; // [RQ20]
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         TRIG_MODE_OUT <= 3'(icb_pkg::TRIG_NONE);
      end else begin
         case (trig_reg[icb_pkg::BIT_LATCH +: 3]) // [RQ17]
            3'h4: TRIG_MODE_OUT <= 3'(icb_pkg::TRIG_EDGE); // [RQ18]
            3'h2: TRIG_MODE_OUT <= 3'(icb_pkg::TRIG_LEVEL); // [RQ18]
            3'h3: TRIG_MODE_OUT <= 3'(icb_pkg::TRIG_LATCHED); // [RQ18]
            3'h6: TRIG_MODE_OUT <= 3'(icb_pkg::TRIG_LEVEL_FIFO); // [RQ18]
            default: TRIG_MODE_OUT <= 3'(icb_pkg::TRIG_NONE);
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   sequence s_boot_write;
      boot_req && boot_state == icb_pkg::BOOT_IDLE;
   endsequence
   sequence s_swrst_write;
      swrst_req;
   endsequence

   property p_reload_self_clear;
      s_boot_write |=> RELOAD_BUSY_OUT ##[1:BOOT_BOUND] !RELOAD_BUSY_OUT;
   endproperty
   a_reload_self_clear: assert property (p_reload_self_clear) else $error("reload bit did not clear"); // [RQ1]

   property p_soft_reset;
      s_swrst_write |=> SOFT_RESET_OUT && iface_reg == icb_pkg::RST_IFACE_RESET &&
         route_reg == icb_pkg::RST_IRQ_ROUTE ##1 !SOFT_RESET_OUT;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults"); // [RQ7]

   property p_hold_freeze;
      iface_reg[icb_pkg::BIT_HOLD] && !(lo_read_reg && hi_read_reg) |=> $stable(data_hold_reg);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("held data pair changed"); // [RQ2]

   property p_polarity_idle;
      !iface_reg[icb_pkg::BIT_DRV] && !pin_a_act |=> IRQ_A_OUT == $past(iface_reg[icb_pkg::BIT_POL]);
   endproperty
   a_polarity_idle: assert property (p_polarity_idle) else $error("idle pin level wrong"); // [RQ3]

   property p_open_drain_low;
      iface_reg[icb_pkg::BIT_DRV] && $past(iface_reg[icb_pkg::BIT_DRV]) |-> !IRQ_A_OUT && !IRQ_B_OUT;
   endproperty
   a_open_drain_low: assert property (p_open_drain_low) else $error("open drain drove high"); // [RQ4]

   property p_merge;
      route_reg[icb_pkg::BIT_MERGE] && IRQ_SRC_B_IN && !iface_reg[icb_pkg::BIT_DRV] |=>
         IRQ_A_OUT != $past(iface_reg[icb_pkg::BIT_POL]) && IRQ_B_OUT == $past(iface_reg[icb_pkg::BIT_POL]);
   endproperty
   a_merge: assert property (p_merge) else $error("merged source missing on first pin"); // [RQ9]

   property p_ready_hide;
      route_reg[icb_pkg::BIT_HIDE] && SETTLE_XL_IN && !IRQ_SRC_A_IN && !route_reg[icb_pkg::BIT_MERGE] |-> !pin_a_act;
   endproperty
   a_ready_hide: assert property (p_ready_hide) else $error("data ready shown while settling"); // [RQ10]

   property p_auto_inc;
      step && iface_reg[icb_pkg::BIT_INC] && cur_addr < icb_pkg::ADDR_GYRO_FIRST |=>
         u_ptr.addr_reg == $past(cur_addr) + 7'h01;
   endproperty
   a_auto_inc: assert property (p_auto_inc) else $error("address did not advance"); // [RQ6]

   property p_lpf1_aux;
      GYRO_LPF1_EN_OUT |-> $past(!AUX_SPI_EN_IN);
   endproperty
   a_lpf1_aux: assert property (p_lpf1_aux) else $error("low-pass enabled with auxiliary port on"); // [RQ12]

   property p_selftest_legal;
      GYRO_ST_OUT != icb_pkg::GST_BAD && ACCEL_ST_OUT != icb_pkg::AST_BAD;
   endproperty
   a_selftest_legal: assert property (p_selftest_legal) else $error("forbidden self-test code driven"); // [RQ15] [RQ16]

endmodule : icb_ctrl_bank
`default_nettype wire

// >>> rtl/icb_irq_pin.sv
// Purpose: Drives one interrupt pin with selectable level and drive type
// Assumes: active is a synchronous level
// Notes: Open drain only ever pulls low; the board pull-up makes the high
`timescale 1ns/1ps
`default_nettype none
module icb_irq_pin (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic active,
   icb_cfg_if.pin cfg,
   output logic pin_out,
   output logic pin_oe
);
   logic level;

   assign level = active ^ cfg.irq_pol; // [RQ3]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b1;
      end else if (cfg.irq_od) begin
         pin_out <= 1'b0; // [RQ4]
         pin_oe <= ~level;
      end else begin
         pin_out <= level; // [RQ4]
         pin_oe <= 1'b1;
      end
   end
endmodule : icb_irq_pin
`default_nettype wire

// >>> verif/icb_host.sv
// Purpose: Host model issuing byte accesses on the access port
// Assumes: Strobes change at the falling edge
// Notes: Returns the byte really sent, or the byte read
`timescale 1ns/1ps
`default_nettype none
module icb_host (
   // Clock and read data
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   // Access strobes
   output logic start_out,
   output logic wr_out,
   output logic rd_out,
   output logic [6:0] addr_out,
   output logic [7:0] wdata_out
);
   initial {start_out, wr_out, rd_out, addr_out, wdata_out} = '0;
   task automatic op(input logic w, input logic s, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      if (a == 7'h12) d[1] = 1'b0;
      if (a == 7'h13) d = d & 8'h6e;
      if (a == 7'h14) d[4] = 1'b0;
      if (a == 7'h14 && d[3:2] == 2'h2) d[3:2] = 2'h0;
      if (a == 7'h14 && d[1:0] == 2'h3) d[1:0] = 2'h0;
      @(negedge clk_in);
      {start_out, wr_out, rd_out, addr_out, wdata_out} = {s, w, !w, a, d};
      @(negedge clk_in);
      {start_out, wr_out, rd_out} = 3'h0;
      q = w ? d : rdata_in;
   endtask : op
endmodule : icb_host
`default_nettype wire

// >>> verif/tb.sv
// Purpose: Self-checking bench of the control register bank
// Assumes: Host model owns the access port
// Notes: Reload shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int RC = 4;
   logic CLK_IN = 1'b0, RST_N_IN = 1'b0, ACC_START_IN, ACC_WR_IN, ACC_RD_IN, ACC_RVALID_OUT;
   logic [6:0] ACC_ADDR_IN, sens = 7'h00;
   logic [7:0] ACC_WDATA_IN, ACC_RDATA_OUT, d, q;
   logic [15:0] GYRO_DATA_IN = 16'h0000;
   logic GYRO_DATA_VALID_IN = 1'b0, DATA_READY_INDICATION_XL_IN, DATA_READY_INDICATION_G_IN, SETTLE_XL_IN, SETTLE_G_IN, xa, xg, la, lb;
   logic IRQ_SRC_A_IN, IRQ_SRC_B_IN, AUX_SPI_EN_IN, IRQ_A_OUT, IRQ_A_OE_OUT, IRQ_B_OUT, IRQ_B_OE_OUT;
   logic RELOAD_BUSY_OUT, SOFT_RESET_OUT, SPI_3WIRE_OUT, I2C_PORT_EN_OUT, GYRO_SLEEP_OUT, GYRO_LPF1_EN_OUT;
   logic ACCEL_ULP_OUT, ACCEL_HP_OFF_OUT, OFFSET_WEIGHT_OUT;
   logic [2:0] GYRO_BW_OUT, TRIG_MODE_OUT;
   logic [1:0] GYRO_ST_OUT, ACCEL_ST_OUT;
   int m[4] = '{4, 0, 0, 0};
   int k[4] = '{'h7c, 'h6e, 'hef, 'hff};
   int tt[4] = '{4, 2, 3, 6};
   int seed = 32, err_total = 0, total_checks = 0, cyc = 0, n, i, r;
   assign {AUX_SPI_EN_IN, IRQ_SRC_B_IN, IRQ_SRC_A_IN, SETTLE_G_IN, SETTLE_XL_IN, DATA_READY_INDICATION_G_IN, DATA_READY_INDICATION_XL_IN} = sens;
   icb_ctrl_bank #(.RELOAD_CYCLES(RC)) DUT (.*);
   icb_host host (.clk_in(CLK_IN), .rdata_in(ACC_RDATA_OUT), .start_out(ACC_START_IN), .wr_out(ACC_WR_IN),
      .rd_out(ACC_RD_IN), .addr_out(ACC_ADDR_IN), .wdata_out(ACC_WDATA_IN));
   initial forever #12.5 CLK_IN = ~CLK_IN;
   always @(posedge CLK_IN) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rdall;
      for (int j = 0; j < 4; j++) begin
         host.op(1'b0, j == 0, 7'h12, 8'h00, q);
         chk({ACC_RVALID_OUT, q}, {1'b1, 8'(m[j])});
      end
   endtask : rdall
   task automatic pulse(input logic [15:0] v);
      @(negedge CLK_IN);
      {GYRO_DATA_IN, GYRO_DATA_VALID_IN} = {v, 1'b1};
      @(negedge CLK_IN);
      GYRO_DATA_VALID_IN = 1'b0;
   endtask : pulse
   function automatic int tmode(input int t);
      case (t) 4: return 1; 2: return 2; 3: return 3; 6: return 4; default: return 0; endcase
   endfunction : tmode
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(negedge CLK_IN);
      RST_N_IN = 1'b1;
      rdall;
      $display("done reset");
      for (r = 0; r < 8; r++) begin
         for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            if (i == 0) d = d & 8'h7c | 8'h04;
            if (i == 3) d[7:5] = 3'(tt[r % 4]);
            host.op(1'b1, i == 0, 7'(7'h12 + i), d, q);
            m[i] = q & k[i];
         end
         rdall;
         chk({SPI_3WIRE_OUT, I2C_PORT_EN_OUT, GYRO_SLEEP_OUT, ACCEL_ULP_OUT, ACCEL_HP_OFF_OUT, OFFSET_WEIGHT_OUT,
            GYRO_BW_OUT, GYRO_ST_OUT, ACCEL_ST_OUT, TRIG_MODE_OUT}, {m[0][3], !m[1][2], m[1][6], m[2][7], m[3][4],
            m[3][3], m[3][2:0], m[2][3:2], m[2][1:0], 3'(tmode(m[3][7:5]))});
         repeat (4) begin
            sens = 7'($random(seed));
            repeat (3) @(negedge CLK_IN);
            xa = sens[0] & !(m[1][3] & sens[2]);
            xg = sens[1] & !(m[1][3] & sens[3]);
            la = (sens[4] | xa | m[1][5] & (sens[5] | xg)) ^ m[0][5];
            lb = (!m[1][5] & (sens[5] | xg)) ^ m[0][5];
            // A released pin reads high through the board pull-up
            chk({IRQ_A_OE_OUT ? IRQ_A_OUT : 1'b1, IRQ_A_OE_OUT, IRQ_B_OE_OUT ? IRQ_B_OUT : 1'b1, IRQ_B_OE_OUT,
               GYRO_LPF1_EN_OUT}, {la, !(m[0][4] & la), lb, !(m[0][4] & lb), m[1][1] & !sens[6]});
         end
      end
      $display("done fields");
      host.op(1'b1, 1'b1, 7'h12, 8'h00, q);
      host.op(1'b0, 1'b1, 7'h12, 8'h00, q);
      host.op(1'b0, 1'b0, 7'h12, 8'h00, d);
      chk({q, d}, 16'h0000);
      host.op(1'b1, 1'b1, 7'h12, 8'h01, q);
      chk(SOFT_RESET_OUT, 1'b1);
      m = '{4, 0, 0, 0};
      rdall;
      $display("done soft reset");
      host.op(1'b1, 1'b1, 7'h12, 8'h84, q);
      host.op(1'b0, 1'b1, 7'h12, 8'h00, q);
      chk(q, 8'h84);
      for (n = 0; RELOAD_BUSY_OUT === 1'b1 && n < 50; n++) @(negedge CLK_IN);
      chk(n, RC - 2);
      rdall;
      $display("done reload");
      for (i = 0; i < 2; i++) begin
         host.op(1'b1, 1'b1, 7'h12, i ? 8'h44 : 8'h04, q);
         pulse(16'h1234 + i);
         pulse(16'habcd);
         host.op(1'b0, 1'b1, 7'h22, 8'h00, q);
         host.op(1'b0, 1'b0, 7'h22, 8'h00, d);
         chk({d, q}, i ? 16'h1235 : 16'habcd);
      end
      $display("done hold");
      // Burst past the end of the gyro or the combined wrap region must land on the low data byte
      for (i = 0; i < 2; i++) begin
         host.op(1'b1, 1'b1, 7'h14, i ? 8'h60 : 8'h40, q);
         host.op(1'b0, 1'b1, i ? 7'h2d : 7'h27, 8'h00, q);
         host.op(1'b0, 1'b0, 7'h22, 8'h00, d);
         chk({q, d}, 16'h0035);
      end
      $display("done wrap");
      test_done;
   end
endmodule : tb
`default_nettype wire
